// ===== core/apc_pkg.sv
// apc_pkg: register map, field layout, reset values and timing constants
// assumes a 32-bit apb slave with word-aligned registers
package apc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] POWER_CTRL_ADDR = 8'h00;
  localparam logic [7:0] REF_SEL_ADDR = 8'h04;
  // ----------------------------------------
  // power control fields
  // ----------------------------------------
  localparam int CONV_A_PD_BIT = 0;
  localparam int CONV_B_PD_BIT = 1;
  localparam int REF_PC_BIT = 2;
  localparam int AUTO_POWER_DOWN_BIT = 3;
  localparam int DELAY_LSB = 4;
  localparam int DELAY_W = 6;
  localparam int CONV_A_STS_BIT = 10;
  localparam int CONV_B_STS_BIT = 11;
  localparam int REF_STS_BIT = 12;
  localparam int AUTO_STANDBY_BIT = 15;
  // ----------------------------------------
  // reference select fields
  // ----------------------------------------
  localparam int LOW_SEL_BIT = 14;
  localparam int HIGH_SEL_BIT = 15;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [5:0] DELAY_RST = 6'h0D;
  localparam logic CONV_PD_RST = 1'b1;
  localparam logic REF_PC_RST = 1'b1;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_ONE = 6'h01;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : apc_pkg

// ===== core/apc_delay_cnt.sv
// apc_delay_cnt: power-up delay down-counter
// assumes load is a one-cycle pulse in the pclk domain
`timescale 1ns/1ns
module apc_delay_cnt #(
  parameter int W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic busy
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy = (cnt_r != '0);

  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && !load) |=> cnt_r == $past(cnt_r) - 1'b1)
    else $error("delay counter did not step");
endmodule : apc_delay_cnt

// ===== core/apc_power_ctrl.sv
// apc_power_ctrl: adc power management and reference select, apb slave
// assumes scan logic supplies scan requests and done pulses in pclk domain
// Function
// - conv a status sets at once on power-down, falls after delay without auto power-down
// - in auto power-down, conv a status shows its actual power state
// - six-bit delay field sets clocks from power-up to scan permission
// - auto modes hold scan start for the delay on each idle-to-active
// - delay field resets to thirteen clocks
// - auto power-down wins over auto standby
// - auto power-down powers needed converters during delay, scans, then powers down
// - mode enabled mid-scan waits until idle before low power
// - looping scans never go idle, so never enter low power
// - reference control 0 keeps reference on, 1 follows converters
// - with reference control 1, reference powers down when both converters are down
// - conv b power-down acts at once, results then flagged invalid
// - conv b on continuously without auto power-down, on demand with it
// - conv a power-down acts at once, results then flagged invalid
// - conv a on continuously without auto power-down, on demand with it
// - standby clock and current while idle in auto standby
// - conv b status sets at once on power-down, falls after delay without auto power-down
// - reference status 0 when enabled, 1 when disabled
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
module apc_power_ctrl #(
  parameter int DELAY_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scan_req,
  input wire logic [1:0] scan_need,
  input wire logic scan_done,
  input wire logic scan_loop,
  output logic scan_grant,
  output logic scan_active,
  output logic conv_a_power_on,
  output logic conv_b_power_on,
  output logic reference_power_on,
  output logic conv_a_result_invalid,
  output logic conv_b_result_invalid,
  output logic standby_mode,
  output logic high_reference_select,
  output logic low_reference_select
);
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SCAN} apc_state_type;

  apc_state_type state_r, state_nxt;
  logic conv_a_power_down_r, conv_b_power_down_r, reference_power_control_r;
  logic auto_power_down_r, auto_standby_r;
  logic [DELAY_W-1:0] power_up_delay_r;
  logic [DELAY_W-1:0] dly_val;
  logic high_sel_r, low_sel_r;
  logic [1:0] need_r;
  logic conv_a_power_status, conv_b_power_status, reference_power_status;
  logic wr_en, wr_pc, wr_rs, a_clear, b_clear, auto_start, dly_load, dly_busy;
  logic man_busy_a_r, man_busy_b_r;
  logic auto_pd_mode, auto_sb_mode, on_a, on_b;

  // ----------------------------------------
  // apb access
  // ----------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb begin
    wr_pc = 1'b0;
    wr_rs = 1'b0;
    pslverr = 1'b0;
    if (paddr == apc_pkg::POWER_CTRL_ADDR) begin
      wr_pc = wr_en;
    end else if (paddr == apc_pkg::REF_SEL_ADDR) begin
      wr_rs = wr_en;
    end else begin
      pslverr = psel && penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_a_power_down_r <= apc_pkg::CONV_PD_RST;
      conv_b_power_down_r <= apc_pkg::CONV_PD_RST;
      reference_power_control_r <= apc_pkg::REF_PC_RST;
      auto_power_down_r <= 1'b0;
      auto_standby_r <= 1'b0;
      power_up_delay_r <= DELAY_W'(apc_pkg::DELAY_RST);
    end else if (wr_pc) begin
      conv_a_power_down_r <= pwdata[apc_pkg::CONV_A_PD_BIT];
      conv_b_power_down_r <= pwdata[apc_pkg::CONV_B_PD_BIT];
      reference_power_control_r <= pwdata[apc_pkg::REF_PC_BIT];
      auto_power_down_r <= pwdata[apc_pkg::AUTO_POWER_DOWN_BIT];
      auto_standby_r <= pwdata[apc_pkg::AUTO_STANDBY_BIT];
      power_up_delay_r <= pwdata[apc_pkg::DELAY_LSB +: DELAY_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_sel_r <= 1'b0;
      low_sel_r <= 1'b0;
    end else if (wr_rs) begin
      high_sel_r <= pwdata[apc_pkg::HIGH_SEL_BIT];
      low_sel_r <= pwdata[apc_pkg::LOW_SEL_BIT];
    end
  end
  assign high_reference_select = high_sel_r;
  assign low_reference_select = low_sel_r;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // auto power-down wins
  assign auto_pd_mode = auto_power_down_r;
  assign auto_sb_mode = auto_standby_r && !auto_power_down_r;

  // manual power-up events start the delay
  assign a_clear = wr_pc && conv_a_power_down_r && !pwdata[apc_pkg::CONV_A_PD_BIT];
  assign b_clear = wr_pc && conv_b_power_down_r && !pwdata[apc_pkg::CONV_B_PD_BIT];
  assign auto_start = (state_r == ST_IDLE) && scan_req && (auto_pd_mode || auto_sb_mode);
  assign dly_load = auto_start || a_clear || b_clear;
  // a write that clears a power-down bit counts the delay it writes
  assign dly_val = wr_pc ? pwdata[apc_pkg::DELAY_LSB +: DELAY_W] : power_up_delay_r;

  apc_delay_cnt #(
    .W(DELAY_W)
  ) u_dly (
    .pclk(pclk),
    .presetn(presetn),
    .load(dly_load),
    .load_val(dly_val),
    .busy(dly_busy)
  );

  // which converter is waiting on a manual power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      man_busy_a_r <= 1'b0;
      man_busy_b_r <= 1'b0;
    end else begin
      man_busy_a_r <= a_clear || (man_busy_a_r && dly_busy && !conv_a_power_down_r);
      man_busy_b_r <= b_clear || (man_busy_b_r && dly_busy && !conv_b_power_down_r);
    end
  end

  // ----------------------------------------
  // scan sequencing
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (auto_start) begin
          state_nxt = ST_DELAY;
        end else if (scan_req && !dly_busy) begin
          state_nxt = ST_SCAN;
        end
      end
      ST_DELAY: begin
        if (!dly_busy) begin
          state_nxt = ST_SCAN;
        end
      end
      ST_SCAN: begin
        // leave only when scan done and not looping
        if (scan_done && !scan_loop) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      need_r <= 2'b00;
    end else if ((state_r == ST_IDLE) && scan_req) begin
      need_r <= scan_need;
    end
  end

  assign scan_grant = (state_r == ST_SCAN);
  assign scan_active = (state_r != ST_IDLE);

  // ----------------------------------------
  // power outputs
  // ----------------------------------------
  // converter power
  assign on_a = auto_pd_mode ? (scan_active && need_r[0]) : 1'b1;
  assign on_b = auto_pd_mode ? (scan_active && need_r[1]) : 1'b1;
  assign conv_a_power_on = on_a && !conv_a_power_down_r;
  assign conv_b_power_on = on_b && !conv_b_power_down_r;
  assign conv_a_result_invalid = conv_a_power_down_r;
  assign conv_b_result_invalid = conv_b_power_down_r;
  assign reference_power_on = !reference_power_control_r ||
    conv_a_power_on || conv_b_power_on;
  assign standby_mode = auto_sb_mode && !scan_active;

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // converter and reference status
  assign conv_a_power_status = auto_pd_mode ? !conv_a_power_on :
    (conv_a_power_down_r || (man_busy_a_r && dly_busy));
  assign conv_b_power_status = auto_pd_mode ? !conv_b_power_on :
    (conv_b_power_down_r || (man_busy_b_r && dly_busy));
  assign reference_power_status = !reference_power_on;

  always_comb begin
    prdata = apc_pkg::RDATA_ZERO;
    if (paddr == apc_pkg::POWER_CTRL_ADDR) begin
      prdata[apc_pkg::CONV_A_PD_BIT] = conv_a_power_down_r;
      prdata[apc_pkg::CONV_B_PD_BIT] = conv_b_power_down_r;
      prdata[apc_pkg::REF_PC_BIT] = reference_power_control_r;
      prdata[apc_pkg::AUTO_POWER_DOWN_BIT] = auto_power_down_r;
      prdata[apc_pkg::DELAY_LSB +: DELAY_W] = power_up_delay_r;
      prdata[apc_pkg::CONV_A_STS_BIT] = conv_a_power_status;
      prdata[apc_pkg::CONV_B_STS_BIT] = conv_b_power_status;
      prdata[apc_pkg::REF_STS_BIT] = reference_power_status;
      prdata[apc_pkg::AUTO_STANDBY_BIT] = auto_standby_r;
    end else if (paddr == apc_pkg::REF_SEL_ADDR) begin
      prdata[apc_pkg::HIGH_SEL_BIT] = high_sel_r;
      prdata[apc_pkg::LOW_SEL_BIT] = low_sel_r;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sts_a_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_pc && pwdata[apc_pkg::CONV_A_PD_BIT]) |=> conv_a_power_status)
    else $error("conv a status not set on power-down");
  sts_b_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_pc && pwdata[apc_pkg::CONV_B_PD_BIT]) |=> conv_b_power_status)
    else $error("conv b status not set on power-down");
  sts_a_auto_a: assert property (@(posedge pclk) disable iff (!presetn)
    auto_pd_mode |-> (conv_a_power_status == !conv_a_power_on))
    else $error("conv a status not tracking power");
  delay_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    auto_start |=> !scan_grant)
    else $error("scan granted without delay");
  pd_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_a_power_down_r |-> !conv_a_power_on)
    else $error("conv a on while powered down");
  pd_b_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_b_power_down_r |-> !conv_b_power_on)
    else $error("conv b on while powered down");
  ref_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reference_power_control_r && !conv_a_power_on && !conv_b_power_on)
    |-> reference_power_status)
    else $error("reference on with both converters down");
  loop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (scan_grant && scan_loop) |=> scan_active)
    else $error("looping scan went idle");
  auto_pd_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    auto_power_down_r |-> !standby_mode)
    else $error("standby used under auto power-down");
  idle_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_power_down_r && !scan_active) |-> (!conv_a_power_on && !conv_b_power_on))
    else $error("converter powered while idle in auto power-down");
  sts_a_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_power_down_r && !scan_active) |-> conv_a_power_status)
    else $error("conv a status clear while idle in auto power-down");
  man_a_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_power_down_r && !conv_a_power_down_r) |-> conv_a_power_on)
    else $error("conv a off without auto power-down");
  man_b_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_power_down_r && !conv_b_power_down_r) |-> conv_b_power_on)
    else $error("conv b off without auto power-down");
  sts_a_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_power_down_r && !conv_a_power_down_r && !dly_busy) |-> !conv_a_power_status)
    else $error("conv a status held after delay");
  sts_b_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_power_down_r && !conv_b_power_down_r && !dly_busy) |-> !conv_b_power_status)
    else $error("conv b status held after delay");
  ref_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !reference_power_control_r |-> reference_power_on)
    else $error("reference off while forced on");
  scan_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (scan_grant && !scan_done) |=> scan_grant)
    else $error("scan cut short");
  stby_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_standby_r && !auto_power_down_r && (state_r == ST_IDLE)) |-> standby_mode)
    else $error("no standby while idle in auto standby");
  sel_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_rs |=> (high_reference_select == $past(pwdata[apc_pkg::HIGH_SEL_BIT])))
    else $error("high reference select not written");
  sel_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_rs |=> (low_reference_select == $past(pwdata[apc_pkg::LOW_SEL_BIT])))
    else $error("low reference select not written");
endmodule : apc_power_ctrl

// ===== bench/tb.sv
// tb: self-checking bench for apc_power_ctrl over apb and the scan handshake
// assumes the scan handshake of apc_power_ctrl; apb transfers wait on pready
`timescale 1ns/1ns
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic scan_req, scan_done, scan_loop, scan_grant, scan_active;
  logic [1:0] scan_need;
  logic ca_on, cb_on, ref_on, ca_inv, cb_inv, stby, hsel, lsel;
  int bad_count, tests_run, cyc, n;
  apc_power_ctrl #(.DELAY_W(6)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_req(scan_req), .scan_need(scan_need),
    .scan_done(scan_done), .scan_loop(scan_loop), .scan_grant(scan_grant),
    .scan_active(scan_active), .conv_a_power_on(ca_on), .conv_b_power_on(cb_on),
    .reference_power_on(ref_on), .conv_a_result_invalid(ca_inv),
    .conv_b_result_invalid(cb_inv), .standby_mode(stby), .high_reference_select(hsel),
    .low_reference_select(lsel));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic conclude;
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] pc(input logic pa, pb, rc, ap, input logic [5:0] dl,
    input logic sa, sb, sr, ab);
    pc = '0;
    pc[apc_pkg::CONV_A_PD_BIT] = pa;
    pc[apc_pkg::CONV_B_PD_BIT] = pb;
    pc[apc_pkg::REF_PC_BIT] = rc;
    pc[apc_pkg::AUTO_POWER_DOWN_BIT] = ap;
    pc[apc_pkg::DELAY_LSB +: 6] = dl;
    pc[apc_pkg::CONV_A_STS_BIT] = sa;
    pc[apc_pkg::CONV_B_STS_BIT] = sb;
    pc[apc_pkg::REF_STS_BIT] = sr;
    pc[apc_pkg::AUTO_STANDBY_BIT] = ab;
  endfunction : pc
  task automatic wgrant(input int d);
    n = 0;
    while (scan_grant !== 1'b1 && n < 60) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n >= d + 1 && n <= d + 3), 32'h1);
  endtask : wgrant
  task automatic done_pulse;
    @(posedge pclk);
    scan_done <= 1'b1;
    @(posedge pclk);
    scan_done <= 1'b0;
    @(negedge pclk);
  endtask : done_pulse
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, scan_req, scan_done, scan_loop} = '0;
    paddr = '0;
    pwdata = '0;
    scan_need = 2'h0;
    presetn = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({ca_on, cb_on, ref_on, ca_inv, cb_inv, scan_grant}, 32'h06);
    apb(0, apc_pkg::POWER_CTRL_ADDR, 0);
    chk(rd, pc(1, 1, 1, 0, 6'h0D, 1, 1, 1, 0));
    apb(1, apc_pkg::REF_SEL_ADDR, 32'h0000_C000);
    apb(0, apc_pkg::REF_SEL_ADDR, 0);
    chk(rd, 32'h0000_C000);
    @(negedge pclk);
    chk({hsel, lsel}, 32'h3);
    apb(1, apc_pkg::REF_SEL_ADDR, 32'h0000_4000);
    @(negedge pclk);
    chk({hsel, lsel}, 32'h1);
    apb(0, 8'h08, 0);
    chk({er, rd[15:0]}, 32'h10000);
    // manual power-up of converter a with a six-cycle delay
    apb(1, apc_pkg::POWER_CTRL_ADDR, pc(0, 1, 1, 0, 6'h06, 0, 0, 0, 0));
    apb(0, apc_pkg::POWER_CTRL_ADDR, 0);
    chk(rd[apc_pkg::CONV_A_STS_BIT], 32'h1);
    @(negedge pclk);
    chk({ca_on, ca_inv, cb_on, cb_inv, ref_on}, 32'h13);
    apb(0, apc_pkg::POWER_CTRL_ADDR, 0);
    chk(rd[apc_pkg::CONV_A_STS_BIT], 32'h1);
    apb(0, apc_pkg::POWER_CTRL_ADDR, 0);
    chk(rd[apc_pkg::CONV_A_STS_BIT], 32'h0);
    @(posedge pclk);
    scan_req <= 1'b1;
    scan_need <= 2'h1;
    wgrant(0);
    @(posedge pclk);
    scan_req <= 1'b0;
    done_pulse();
    chk({scan_active, ca_on}, 32'h1);
    repeat (8) @(posedge pclk);
    apb(0, apc_pkg::POWER_CTRL_ADDR, 0);
    chk(rd, pc(0, 1, 1, 0, 6'h06, 0, 1, 0, 0));
    apb(1, apc_pkg::POWER_CTRL_ADDR, pc(1, 1, 1, 0, 6'h06, 0, 0, 0, 0));
    apb(0, apc_pkg::POWER_CTRL_ADDR, 0);
    chk(rd, pc(1, 1, 1, 0, 6'h06, 1, 1, 1, 0));
    @(negedge pclk);
    chk({ca_on, ref_on}, 32'h0);
    apb(1, apc_pkg::POWER_CTRL_ADDR, pc(1, 1, 0, 0, 6'h06, 0, 0, 0, 0));
    @(negedge pclk);
    chk(ref_on, 32'h1);
    // auto power-down with auto standby also set
    apb(1, apc_pkg::POWER_CTRL_ADDR, pc(0, 0, 1, 1, 6'h02, 0, 0, 0, 1));
    repeat (4) @(posedge pclk);
    apb(0, apc_pkg::POWER_CTRL_ADDR, 0);
    chk(rd[12:10], 32'h7);
    @(negedge pclk);
    chk({ca_on, cb_on, stby}, 32'h0);
    @(posedge pclk);
    scan_req <= 1'b1;
    scan_need <= 2'h1;
    wgrant(2);
    chk({ca_on, cb_on, scan_active}, 32'h5);
    apb(0, apc_pkg::POWER_CTRL_ADDR, 0);
    chk(rd[12:10], 32'h2);
    scan_loop <= 1'b1;
    done_pulse();
    chk({scan_active, ca_on}, 32'h3);
    @(posedge pclk);
    scan_loop <= 1'b0;
    scan_req <= 1'b0;
    done_pulse();
    chk({scan_active, ca_on, cb_on}, 32'h0);
    // auto standby alone, then auto power-down switched on mid-scan
    apb(1, apc_pkg::POWER_CTRL_ADDR, pc(0, 0, 1, 0, 6'h03, 0, 0, 0, 1));
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk({stby, ca_on, cb_on}, 32'h7);
    chk({ca_inv, cb_inv}, 32'h0);
    @(posedge pclk);
    scan_req <= 1'b1;
    scan_need <= 2'h3;
    wgrant(3);
    chk(stby, 32'h0);
    apb(1, apc_pkg::POWER_CTRL_ADDR, pc(0, 0, 1, 1, 6'h03, 0, 0, 0, 1));
    @(negedge pclk);
    chk({scan_grant, ca_on, cb_on}, 32'h7);
    @(posedge pclk);
    scan_req <= 1'b0;
    done_pulse();
    chk({scan_active, ca_on, cb_on}, 32'h0);
    conclude();
  end
endmodule : tb
